// file: verilog/fppmp_pkg.sv
package fppmp_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BRIGHT = 8'h04;
  localparam logic [7:0] ADDR_GEOM   = 8'h08;
  localparam logic [7:0] ADDR_FRAMES = 8'h0C;

  // Control register fields
  localparam int         CTRL_W        = 10;
  localparam int         CTRL_MODE_LSB = 0;
  localparam int         CTRL_PWR_BIT  = 3;
  localparam int         CTRL_BKL_BIT  = 4;
  localparam int         CTRL_FUNC_LSB = 5;
  localparam int         CTRL_DIM_BIT  = 7;
  localparam int         CTRL_SER_BIT  = 8;
  localparam int         CTRL_EDGE_BIT = 9;
  localparam logic [9:0] CTRL_RESET    = 10'h200;

  // Brightness pin functions
  localparam logic [1:0] FUNC_LEVEL = 2'h0;
  localparam logic [1:0] FUNC_PWM   = 2'h2;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // Largest panel geometry
  localparam logic [9:0] MAX_H = 10'h320;
  localparam logic [9:0] MAX_V = 10'h258;

  typedef enum logic [2:0] {
    MODE_TFT18     = 3'h0,
    MODE_TFT12     = 3'h1,
    MODE_TFT9      = 3'h2,
    MODE_STN_DUAL  = 3'h3,
    MODE_STN_SINGLE = 3'h4,
    MODE_STN_MONO  = 3'h5
  } fppmp_mode_t;

  // Pixel word from the display controller
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
    logic [7:0] upper;
    logic [7:0] lower;
    logic       hsync;
    logic       vsync;
    logic       de;
  } fppmp_pix_t;

  // Lines toward the panel
  typedef struct packed {
    logic        line_clk;
    logic        frame_clk;
    logic        bias;
    logic [15:0] data;
  } fppmp_panel_t;

endpackage

// file: verilog/fppmp_top.sv
// Summary of operation
// - Colour/mono, TFT/STN, single/dual scan panels up to 800 by 600 pixels.
// - 18-bit TFT: red 5..1 on 15..11, green on 10..5, blue 5..1 on 4..0.
// - 12-bit and 9-bit TFT place colour bits at the top of each field.
// - STN: dual colour split halves, single colour low byte, dual mono nibbles.
// - Clock lines act as sync/data enable for TFT, line/frame/bias for STN.
// - The single STN bias enable line follows the panel power enable bit.
// - Serializer turns the 16 data lines into three pairs plus clock.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module fppmp_top (
  // System clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    rst_n_in,
  // Register port
  input  wire logic [7:0]              addr_in,
  input  wire logic [31:0]             wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [31:0]             rdata_out,
  // Pixel side, on the panel pixel clock
  input  wire logic                    pix_clk_in,
  input  wire fppmp_pkg::fppmp_pix_t   pix_in,
  // Panel lines
  output fppmp_pkg::fppmp_panel_t      panel_out,
  // Power, brightness and serializer control
  output logic                         panel_power_pin_out,
  output logic                         stn_bias_enable_out,
  output logic                         backlight_power_pin_out,
  output logic                         brightness_pin_out,
  output logic                         serializer_enable_pin_out,
  output logic                         expander_edge_line_out
);

  // System domain state
  logic [9:0]  ctrl_q, ctrl_d;
  logic [7:0]  duty_q, duty_d;
  logic [7:0]  pwm_q, pwm_d;
  logic [31:0] rdata_q, rdata_d;
  logic        pwr_q, pwr_d;
  logic        bias_q, bias_d;
  logic        bkl_q, bkl_d;
  logic        bright_q, bright_d;
  logic        ser_q, ser_d;
  logic        edge_q, edge_d;
  logic [15:0] frames_q, frames_d;
  logic [20:0] geom_q, geom_d;
  logic        tog_s1_q, tog_s2_q, tog_s3_q;

  // Pixel domain state
  logic                    prst_s1_q, prst_s2_q;
  logic [2:0]              mode_s1_q, mode_s2_q, mode_s3_q, mode_q;
  logic                    pwr_s1_q, pwr_s2_q;
  fppmp_pkg::fppmp_panel_t panel_q, panel_d;
  logic [9:0]              h_q, h_d;
  logic [9:0]              v_q, v_d;
  logic [9:0]              len_q, len_d;
  logic [9:0]              hold_h_q, hold_h_d;
  logic [9:0]              hold_v_q, hold_v_d;
  logic                    over_q, over_d;
  logic                    hold_over_q, hold_over_d;
  logic                    tog_q, tog_d;
  logic                    de_prev_q, de_prev_d;
  logic                    vs_prev_q, vs_prev_d;

  // Register writes, brightness generator and enable outputs
  always_comb begin
    ctrl_d   = ctrl_q;
    duty_d   = duty_q;
    rdata_d  = 32'h0000_0000;
    frames_d = frames_q;
    geom_d   = geom_q;
    if (wr_in && addr_in == fppmp_pkg::ADDR_CTRL) begin
      ctrl_d = wdata_in[9:0];
    end
    if (wr_in && addr_in == fppmp_pkg::ADDR_BRIGHT) begin
      duty_d = wdata_in[7:0];
    end
    if (rd_in) begin
      unique case (addr_in)
        fppmp_pkg::ADDR_CTRL:   rdata_d = {22'h000000, ctrl_q};
        fppmp_pkg::ADDR_BRIGHT: rdata_d = {24'h000000, duty_q};
        fppmp_pkg::ADDR_GEOM:   rdata_d = {11'h000, geom_q};
        fppmp_pkg::ADDR_FRAMES: rdata_d = {16'h0000, frames_q};
        default:                rdata_d = 32'h0000_0000;
      endcase
    end
    // Geometry snapshot is stable for a whole frame when the toggle arrives
    if (tog_s2_q != tog_s3_q) begin
      geom_d   = {hold_over_q, hold_v_q, hold_h_q};
      frames_d = frames_q + 16'h0001;
    end
    pwm_d    = pwm_q + 8'h01;
    pwr_d    = ctrl_q[fppmp_pkg::CTRL_PWR_BIT];
    bias_d   = ctrl_q[fppmp_pkg::CTRL_PWR_BIT];
    bkl_d    = ctrl_q[fppmp_pkg::CTRL_BKL_BIT];
    ser_d    = ctrl_q[fppmp_pkg::CTRL_SER_BIT];
    edge_d   = ctrl_q[fppmp_pkg::CTRL_EDGE_BIT];
    if (ctrl_q[fppmp_pkg::CTRL_FUNC_LSB +: 2] == fppmp_pkg::FUNC_PWM) begin
      bright_d = (pwm_q < duty_q);
    end else begin
      bright_d = ctrl_q[fppmp_pkg::CTRL_DIM_BIT];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl_q   <= fppmp_pkg::CTRL_RESET;
      duty_q   <= fppmp_pkg::DUTY_RESET;
      pwm_q    <= 8'h00;
      rdata_q  <= 32'h0000_0000;
      pwr_q    <= 1'b0;
      bias_q   <= 1'b0;
      bkl_q    <= 1'b0;
      bright_q <= 1'b0;
      ser_q    <= 1'b0;
      edge_q   <= 1'b1;
      frames_q <= 16'h0000;
      geom_q   <= 21'h000000;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      duty_q   <= duty_d;
      pwm_q    <= pwm_d;
      rdata_q  <= rdata_d;
      pwr_q    <= pwr_d;
      bias_q   <= bias_d;
      bkl_q    <= bkl_d;
      bright_q <= bright_d;
      ser_q    <= ser_d;
      edge_q   <= edge_d;
      frames_q <= frames_d;
      geom_q   <= geom_d;
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  assign rdata_out                 = rdata_q;
  assign panel_power_pin_out       = pwr_q;
  assign stn_bias_enable_out       = bias_q;
  assign backlight_power_pin_out   = bkl_q;
  assign brightness_pin_out        = bright_q;
  assign serializer_enable_pin_out = ser_q;
  assign expander_edge_line_out    = edge_q;

  // Reset, mode and power crossings into the pixel domain
  always_ff @(posedge pix_clk_in) begin
    prst_s1_q <= rst_n_in;
    prst_s2_q <= prst_s1_q;
    mode_s1_q <= ctrl_q[fppmp_pkg::CTRL_MODE_LSB +: 3];
    mode_s2_q <= mode_s1_q;
    mode_s3_q <= mode_s2_q;
    // Mode bits are taken only once two settled samples agree
    if (mode_s2_q == mode_s3_q) begin
      mode_q <= mode_s3_q;
    end
    pwr_s1_q  <= pwr_q;
    pwr_s2_q  <= pwr_s1_q;
  end

  // Pixel bit mapping onto the panel data bus
  always_comb begin
    panel_d           = '0;
    panel_d.line_clk  = pix_in.hsync;
    panel_d.frame_clk = pix_in.vsync;
    panel_d.bias      = pix_in.de;
    unique case (mode_q)
      fppmp_pkg::MODE_TFT18: begin
        panel_d.data = {pix_in.red[5:1], pix_in.green, pix_in.blue[5:1]};
      end
      fppmp_pkg::MODE_TFT12: begin
        panel_d.data = {pix_in.red[3:0], 1'b0, pix_in.green[3:0], 2'b00,
                        pix_in.blue[3:0], 1'b0};
      end
      fppmp_pkg::MODE_TFT9: begin
        panel_d.data = {pix_in.red[2:0], 2'b00, pix_in.green[2:0], 3'b000,
                        pix_in.blue[2:0], 2'b00};
      end
      fppmp_pkg::MODE_STN_DUAL: begin
        panel_d.data = {pix_in.lower, pix_in.upper};
      end
      fppmp_pkg::MODE_STN_SINGLE: begin
        panel_d.data = {8'h00, pix_in.upper};
      end
      fppmp_pkg::MODE_STN_MONO: begin
        panel_d.data = {8'h00, pix_in.lower[3:0], pix_in.upper[3:0]};
      end
      default: begin
        panel_d.data = 16'h0000;
      end
    endcase
    // Unpowered panel sees quiet lines
    if (!pwr_s2_q) begin
      panel_d = '0;
    end
  end

  // Line and frame geometry capture, saturating at the largest panel
  always_comb begin
    h_d         = h_q;
    v_d         = v_q;
    len_d       = len_q;
    hold_h_d    = hold_h_q;
    hold_v_d    = hold_v_q;
    // New frame clears the flag, an overflow in the same cycle still sets it
    over_d      = over_q && !(pix_in.vsync && !vs_prev_q);
    hold_over_d = hold_over_q;
    tog_d       = tog_q;
    de_prev_d   = pix_in.de;
    vs_prev_d   = pix_in.vsync;
    if (pix_in.de) begin
      if (h_q < fppmp_pkg::MAX_H) begin
        h_d = h_q + 10'h001;
      end else begin
        over_d = 1'b1;
      end
    end
    if (de_prev_q && !pix_in.de) begin
      len_d = h_q;
      h_d   = 10'h000;
      if (v_q < fppmp_pkg::MAX_V) begin
        v_d = v_q + 10'h001;
      end else begin
        over_d = 1'b1;
      end
    end
    if (pix_in.vsync && !vs_prev_q) begin
      hold_h_d    = len_q;
      hold_v_d    = v_q;
      hold_over_d = over_q;
      v_d         = 10'h000;
      tog_d       = !tog_q;
    end
  end

  always_ff @(posedge pix_clk_in) begin
    if (!prst_s2_q) begin
      panel_q     <= '0;
      h_q         <= 10'h000;
      v_q         <= 10'h000;
      len_q       <= 10'h000;
      hold_h_q    <= 10'h000;
      hold_v_q    <= 10'h000;
      over_q      <= 1'b0;
      hold_over_q <= 1'b0;
      tog_q       <= 1'b0;
      de_prev_q   <= 1'b0;
      vs_prev_q   <= 1'b0;
    end else begin
      panel_q     <= panel_d;
      h_q         <= h_d;
      v_q         <= v_d;
      len_q       <= len_d;
      hold_h_q    <= hold_h_d;
      hold_v_q    <= hold_v_d;
      over_q      <= over_d;
      hold_over_q <= hold_over_d;
      tog_q       <= tog_d;
      de_prev_q   <= de_prev_d;
      vs_prev_q   <= vs_prev_d;
    end
  end

  assign panel_out = panel_q;

  // Checks on the system side
  a_bias_tracks_power: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    bias_q == pwr_q) else $error("bias enable differs from panel power");
  a_enables_reset_off: assert property (@(posedge mclk_in)
    $rose(rst_n_in) |-> !pwr_q && !bkl_q && !ser_q && edge_q)
    else $error("enables not at default after reset");
  a_power_follows_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wr_in && addr_in == fppmp_pkg::ADDR_CTRL ##1 !(wr_in && addr_in == fppmp_pkg::ADDR_CTRL)
    |=> pwr_q == $past(wdata_in[fppmp_pkg::CTRL_PWR_BIT], 2))
    else $error("panel power did not follow control write");
  a_backlight_follows: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ##1 bkl_q == $past(ctrl_q[fppmp_pkg::CTRL_BKL_BIT]))
    else $error("backlight enable wrong");
  a_bright_level_mode: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ctrl_q[fppmp_pkg::CTRL_FUNC_LSB +: 2] == fppmp_pkg::FUNC_LEVEL
    |=> bright_q == $past(ctrl_q[fppmp_pkg::CTRL_DIM_BIT]))
    else $error("brightness level not driven in function 0");
  a_edge_serial_ctrl: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ##1 edge_q == $past(ctrl_q[fppmp_pkg::CTRL_EDGE_BIT])
    && ser_q == $past(ctrl_q[fppmp_pkg::CTRL_SER_BIT]))
    else $error("edge select or serializer enable wrong");

  // Checks on the pixel side
  a_map_tft18: assert property (@(posedge pix_clk_in) disable iff (!prst_s2_q)
    mode_q == fppmp_pkg::MODE_TFT18 && pwr_s2_q
    |=> panel_q.data == {$past(pix_in.red[5:1]), $past(pix_in.green), $past(pix_in.blue[5:1])})
    else $error("18-bit mapping wrong");
  a_map_tft12: assert property (@(posedge pix_clk_in) disable iff (!prst_s2_q)
    mode_q == fppmp_pkg::MODE_TFT12 && pwr_s2_q
    |=> panel_q.data[15:12] == $past(pix_in.red[3:0]) && panel_q.data[0] == 1'b0)
    else $error("12-bit mapping wrong");
  a_map_stn_dual: assert property (@(posedge pix_clk_in) disable iff (!prst_s2_q)
    mode_q == fppmp_pkg::MODE_STN_DUAL && pwr_s2_q
    |=> panel_q.data == {$past(pix_in.lower), $past(pix_in.upper)})
    else $error("dual scan mapping wrong");
  a_sync_lines: assert property (@(posedge pix_clk_in) disable iff (!prst_s2_q)
    pwr_s2_q |=> panel_q.line_clk == $past(pix_in.hsync)
    && panel_q.frame_clk == $past(pix_in.vsync) && panel_q.bias == $past(pix_in.de))
    else $error("clock lines do not follow sync inputs");
  a_geom_bounded: assert property (@(posedge pix_clk_in) disable iff (!prst_s2_q)
    hold_h_q <= fppmp_pkg::MAX_H && hold_v_q <= fppmp_pkg::MAX_V)
    else $error("geometry beyond largest panel");

endmodule

// file: tb/fppmp_panel_model.sv
`timescale 1ns/1ps
module fppmp_panel_model (
  // Pixel clock and panel lines
  input  wire logic                    pix_clk_in,
  input  wire fppmp_pkg::fppmp_panel_t panel_in,
  // Supply and serializer controls
  input  wire logic                    supply_en_in,
  input  wire logic                    bias_en_in,
  input  wire logic                    backlight_en_in,
  input  wire logic                    serializer_en_in,
  input  wire logic                    edge_sel_in,
  // Panel state
  output logic                         supply_on_out,
  output logic                         backlight_on_out,
  output logic                         strobe_rise_out,
  output logic [15:0]                  frame_data_out
);
  // Logic supply and bias rails come up together
  assign supply_on_out    = supply_en_in & bias_en_in;
  // Backlight supply off while the enable is low
  assign backlight_on_out = backlight_en_in;
  assign strobe_rise_out  = edge_sel_in;
  // Transmitter stays down until enabled; latches enabled pixels
  always @(posedge pix_clk_in) begin
    if (serializer_en_in && panel_in.bias) begin
      frame_data_out <= panel_in.data;
    end
  end
endmodule

// file: tb/fppmp_top_tb.sv
`timescale 1ns/1ps
module fppmp_top_tb;
  // Bench signals
  logic                    mclk_in;
  logic                    rst_n_in;
  logic [7:0]              addr_in;
  logic [31:0]             wdata_in;
  logic                    wr_in;
  logic                    rd_in;
  logic [31:0]             rdata_out;
  logic                    pix_clk_in;
  fppmp_pkg::fppmp_pix_t   pix_in;
  fppmp_pkg::fppmp_pix_t   pat;
  fppmp_pkg::fppmp_panel_t panel_out;
  logic                    pwr;
  logic                    bias;
  logic                    bkl;
  logic                    brt;
  logic                    ser;
  logic                    edg;
  logic                    supply_on;
  logic                    bkl_on;
  logic                    rise_on;
  logic [15:0]             seen_data;
  int                      error_cnt;
  int                      check_count;
  int                      hi_cnt;

  fppmp_top dut_u (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pix_clk_in(pix_clk_in),
    .pix_in(pix_in), .panel_out(panel_out), .panel_power_pin_out(pwr),
    .stn_bias_enable_out(bias), .backlight_power_pin_out(bkl), .brightness_pin_out(brt),
    .serializer_enable_pin_out(ser), .expander_edge_line_out(edg)
  );

  fppmp_panel_model panel_u (
    .pix_clk_in(pix_clk_in), .panel_in(panel_out), .supply_en_in(pwr), .bias_en_in(bias),
    .backlight_en_in(bkl), .serializer_en_in(ser), .edge_sel_in(edg),
    .supply_on_out(supply_on), .backlight_on_out(bkl_on), .strobe_rise_out(rise_on),
    .frame_data_out(seen_data)
  );

  initial begin
    mclk_in = 1'h0;
    forever #20 mclk_in = ~mclk_in;
  end

  initial begin
    pix_clk_in = 1'h0;
    #3.3;
    forever #7.5 pix_clk_in = ~pix_clk_in;
  end

  always @(posedge pix_clk_in) begin
    pix_in <= pat;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Write, then let the enable outputs settle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'h1;
    @(posedge mclk_in);
    wr_in <= 1'h0;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'h1;
    @(posedge mclk_in);
    rd_in <= 1'h0;
    #1;
    chk(rdata_out, exp);
  endtask

  function automatic logic [15:0] exp_data(input int m, input fppmp_pkg::fppmp_pix_t p);
    case (m)
      0: exp_data = {p.red[5:1], p.green, p.blue[5:1]};
      1: exp_data = {p.red[3:0], 1'h0, p.green[3:0], 2'h0, p.blue[3:0], 1'h0};
      2: exp_data = {p.red[2:0], 2'h0, p.green[2:0], 3'h0, p.blue[2:0], 2'h0};
      3: exp_data = {p.lower, p.upper};
      4: exp_data = {8'h00, p.upper};
      5: exp_data = {8'h00, p.lower[3:0], p.upper[3:0]};
      default: exp_data = 16'h0000;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    complete_run();
  end

  initial begin
    rst_n_in = 1'h0;
    addr_in  = 8'h00;
    wdata_in = 32'h0;
    wr_in    = 1'h0;
    rd_in    = 1'h0;
    pat      = '0;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    @(posedge mclk_in);
    #1;
    chk({26'h0, pwr, bias, bkl, brt, ser, edg}, 32'h1);
    rd_reg(fppmp_pkg::ADDR_CTRL, 32'h200);
    rd_reg(fppmp_pkg::ADDR_BRIGHT, 32'h0);
    rd_reg(8'h10, 32'h0);
    // Power up: supply, interface, backlight
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h208);
    chk({29'h0, pwr, bias, supply_on}, 32'h7);
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h308);
    chk({31'h0, ser}, 32'h1);
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h318);
    chk({30'h0, bkl, bkl_on}, 32'h3);
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h118);
    chk({30'h0, edg, rise_on}, 32'h0);
    // Every mode, with a pattern and its inverse
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 2; k++) begin
        pat = '{red: 6'h2D, green: 6'h1B, blue: 6'h36, upper: 8'hA5, lower: 8'h3C,
                hsync: 1'h1, vsync: 1'h0, de: 1'h1};
        if (k == 1) begin
          pat = ~pat;
        end
        wr_reg(fppmp_pkg::ADDR_CTRL, 32'h118 | m);
        repeat (8) @(posedge mclk_in);
        #1;
        chk({13'h0, panel_out}, {13'h0, pat.hsync, pat.vsync, pat.de, exp_data(m, pat)});
        if (k == 0) begin
          chk({16'h0, seen_data}, {16'h0, exp_data(m, pat)});
        end
      end
    end
    // Three lines of five pixels between two frame syncs
    pat = '0;
    @(posedge pix_clk_in);
    pat.vsync <= 1'h1;
    for (int l = 0; l < 3; l++) begin
      @(posedge pix_clk_in);
      pat.vsync <= 1'h0;
      pat.de    <= 1'h1;
      repeat (5) @(posedge pix_clk_in);
      pat.de <= 1'h0;
    end
    @(posedge pix_clk_in);
    pat.vsync <= 1'h1;
    @(posedge pix_clk_in);
    pat.vsync <= 1'h0;
    repeat (8) @(posedge mclk_in);
    rd_reg(fppmp_pkg::ADDR_GEOM, 32'hC05);
    rd_reg(fppmp_pkg::ADDR_FRAMES, 32'hA);
    // Two-level dim, then pulse output at half duty
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h098);
    chk({31'h0, brt}, 32'h1);
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h018);
    chk({31'h0, brt}, 32'h0);
    wr_reg(fppmp_pkg::ADDR_BRIGHT, 32'h80);
    rd_reg(fppmp_pkg::ADDR_BRIGHT, 32'h80);
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h058);
    hi_cnt = 0;
    repeat (256) begin
      @(posedge mclk_in);
      #1;
      hi_cnt += (brt === 1'h1);
    end
    chk(hi_cnt, 32'h80);
    // Power down: backlight, then supply; serializer already off since the dim test
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h008);
    chk({30'h0, bkl, pwr}, 32'h1);
    wr_reg(fppmp_pkg::ADDR_CTRL, 32'h000);
    repeat (8) @(posedge mclk_in);
    #1;
    chk({28'h0, pwr, bias, supply_on, ser}, 32'h0);
    chk({13'h0, panel_out}, 32'h0);
    complete_run();
  end
endmodule
